/* rtl/pmx_pin_mux.sv */
// pin multiplexer for the clock output pin, port a and port b
// assumes pins arrive unsynchronised; config bits come from core logic
//
// Contract
// R1 - clock output 12, 24 or 48 MHz
// R2 - after reset clock output runs 12 MHz
// R3 - cpu control bit 1 tri-states clock
// R4 - no-clock variant uses pin as port e1
// R5 - pa0 gpio or irq0, edge/level selectable
// R6 - pa1 gpio or irq1, edge/level selectable
// R7 - fifo mode: pa2 is polarity-set data oe
// R8 - pa3 selected by wakeup bit7 and oe3
// R9 - wakeup2 gated by enable, polarity bit4
// R10 - wakeup2 transition in suspend restarts, interrupts
// R11 - asserted enabled wakeup2 blocks suspend
// R12 - master drives pa4, pa5 fifo address
// R13 - pa6 commits packet, polarity bit5
// R14 - pa7 gpio, status flag or chip select
// R15 - flag function drives programmable fifo flag
// R16 - chip select gates other fifo strobes
// R17 - port b gpio or low data bus
// R18 - pins released, gpio inputs after reset
// R19 - gpio unless alternate function is selected
`timescale 1ns/10ps
`default_nettype none

module pmx_pin_mux
  #(parameter bit HAS_CORE_CLOCK_OUTPUT_PIN = 1'b1)
  (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   clk48_tick,
  input  wire logic [7:0]             cpu_control_status_reg,
  input  wire logic [1:0]             interface_config_field,
  input  wire logic [7:0]             port_a_alt_config,
  input  wire logic [7:0]             fifo_pin_polarity_reg,
  input  wire logic [7:0]             wakeup_reg,
  input  wire logic                   irq0_trigger_type,
  input  wire logic                   irq1_trigger_type,
  input  wire logic                   cpu_suspended,
  input  wire logic                   fifo_status_flag_four,
  input  wire pmx_pkg::pmx_gpio_t     port_a_gpio,
  input  wire pmx_pkg::pmx_gpio_t     port_b_gpio,
  input  wire logic                   port_e1_dout,
  input  wire logic                   port_e1_oe,
  input  wire logic [7:0]             fifo_data_bus_out,
  input  wire logic                   fifo_data_bus_drive,
  input  wire logic [7:0]             port_a_pin_i,
  input  wire logic [7:0]             port_b_pin_i,
  input  wire logic                   core_clock_output_pin_i,
  output logic                        core_clock_output_pin_o,
  output logic                        core_clock_output_pin_oe,
  output pmx_pkg::pmx_pins_t          port_a_pins,
  output pmx_pkg::pmx_pins_t          port_b_pins,
  output logic [7:0]                  port_a_in_q,
  output logic [7:0]                  port_b_in_q,
  output logic                        port_e1_in_q,
  output logic [7:0]                  fifo_data_bus_in_q,
  output pmx_pkg::pmx_fifo_ctl_t      fifo_ctl_q,
  output logic                        irq0_req_q,
  output logic                        irq1_req_q,
  output logic                        osc_restart_q,
  output logic                        wake_irq_q,
  output logic                        suspend_block_q
  );

  // -------------------------------------------------------------------
  // input synchronisers
  // -------------------------------------------------------------------
  logic [7:0] pa_s1_q, pa_s2_q, pb_s1_q, pb_s2_q;
  logic       pe_s1_q, pe_s2_q;
  logic       pa3_prev_q, irq0_prev_q, pa1_prev_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pa_s1_q <= 8'hFF;
      pa_s2_q <= 8'hFF;
      pb_s1_q <= 8'h00;
      pb_s2_q <= 8'h00;
      pe_s1_q <= 1'h0;
      pe_s2_q <= 1'h0;
    end
    else
    begin
      pa_s1_q <= port_a_pin_i;
      pa_s2_q <= pa_s1_q;
      pb_s1_q <= port_b_pin_i;
      pb_s2_q <= pb_s1_q;
      pe_s1_q <= core_clock_output_pin_i;
      pe_s2_q <= pe_s1_q;
    end
  end

  // -------------------------------------------------------------------
  // function selection
  // -------------------------------------------------------------------
  wire fifo_mode = (interface_config_field == pmx_pkg::IFC_SLAVE_FIFO);
  wire bus_mode  = interface_config_field[1];
  wire sel_irq0  = port_a_alt_config[pmx_pkg::PACFG_IRQ0_BIT];   // R5
  wire sel_irq1  = port_a_alt_config[pmx_pkg::PACFG_IRQ1_BIT];   // R6
  wire sel_flag  = port_a_alt_config[pmx_pkg::PACFG_FLAG_BIT];
  // pa3 is the wakeup input when selected and not driven as gpio
  wire sel_wake  = wakeup_reg[pmx_pkg::WAKE_PA3SEL_BIT]
                   & ~port_a_gpio.oe[3];                           // R8
  wire sel_flag7 = sel_flag;                                       // R14
  wire sel_cs7   = fifo_mode & ~sel_flag;                          // R14

  // alternate-function usage of each port a bit (1 = not gpio)
  wire [7:0] pa_alt = {sel_flag7 | sel_cs7, {3{fifo_mode}}, sel_wake,
                       fifo_mode, sel_irq1, sel_irq0};

  // -------------------------------------------------------------------
  // pin drive: alt functions override gpio only while selected
  // -------------------------------------------------------------------
  logic [7:0] pa_o_d, pa_oe_d, pb_o_d, pb_oe_d;

  // inputs (irq, oe, addr, commit, cs, wakeup) never drive the pad
  always_comb
  begin
    pa_o_d  = port_a_gpio.dout;                                    // R19
    pa_oe_d = port_a_gpio.oe & ~pa_alt;                            // R19
    if (sel_flag7)
    begin
      pa_o_d[7]  = fifo_status_flag_four;                          // R15
      pa_oe_d[7] = 1'b1;                                           // R15
    end
  end

  // port b carries the low data bus in the bus modes
  assign pb_o_d  = bus_mode ? fifo_data_bus_out : port_b_gpio.dout; // R17
  assign pb_oe_d = bus_mode ? {8{fifo_data_bus_drive}}
                            : port_b_gpio.oe;                       // R17

  // registered pad drivers; reset releases every pad
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      port_a_pins <= '0;                                           // R18
      port_b_pins <= '0;                                           // R18
    end
    else
    begin
      port_a_pins <= '{o: pa_o_d, oe: pa_oe_d};
      port_b_pins <= '{o: pb_o_d, oe: pb_oe_d};
    end
  end

  // -------------------------------------------------------------------
  // slave fifo control inputs
  // -------------------------------------------------------------------
  wire oe_act  = pa_s2_q[2] ~^ fifo_pin_polarity_reg[pmx_pkg::POL_DATA_OE_BIT];
  wire pkt_act = pa_s2_q[6] ~^ fifo_pin_polarity_reg[pmx_pkg::POL_PKT_BIT];
  // chip select only matters when it owns pa7; active low
  wire cs_ok   = ~sel_cs7 | ~pa_s2_q[7];                           // R16
  pmx_pkg::pmx_fifo_ctl_t fifo_ctl_d;
  assign fifo_ctl_d = '{data_oe:    fifo_mode & cs_ok & oe_act,    // R7
                        fifo_sel:   fifo_mode ? pa_s2_q[5:4] : 2'h0, // R12
                        pkt_commit: fifo_mode & cs_ok & pkt_act,   // R13
                        cs_ok:      fifo_mode & cs_ok};            // R16

  // -------------------------------------------------------------------
  // external interrupt requests
  // -------------------------------------------------------------------
  // edge mode: one pulse per falling edge; level mode: request while the pin is low
  wire irq0_d = sel_irq0 & (irq0_trigger_type ?
                            (irq0_prev_q & ~pa_s2_q[0]) : ~pa_s2_q[0]);
  wire irq1_d = sel_irq1 & (irq1_trigger_type ?
                            (pa1_prev_q & ~pa_s2_q[1]) : ~pa_s2_q[1]);

  // -------------------------------------------------------------------
  // second wakeup source
  // -------------------------------------------------------------------
  wire wake_en    = sel_wake & wakeup_reg[pmx_pkg::WAKE_EN_BIT];    // R9
  wire wake_level = pa_s2_q[3] ~^ wakeup_reg[pmx_pkg::WAKE_POL_BIT]; // R9
  wire wake_edge  = pa_s2_q[3] ^ pa3_prev_q;
  wire wake_d     = wake_en & cpu_suspended & wake_edge;            // R10
  wire block_d    = wake_en & wake_level;                           // R11

  // registered status toward the core
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      fifo_ctl_q         <= '0;
      irq0_req_q         <= 1'b0;
      irq1_req_q         <= 1'b0;
      osc_restart_q      <= 1'b0;
      wake_irq_q         <= 1'b0;
      suspend_block_q    <= 1'b0;
      irq0_prev_q        <= 1'b1;
      pa1_prev_q         <= 1'b1;
      pa3_prev_q         <= 1'b1;
      port_a_in_q        <= pmx_pkg::RST_BYTE;
      port_b_in_q        <= pmx_pkg::RST_BYTE;
      port_e1_in_q       <= 1'b0;
      fifo_data_bus_in_q <= pmx_pkg::RST_BYTE;
    end
    else
    begin
      fifo_ctl_q         <= fifo_ctl_d;
      irq0_req_q         <= irq0_d;                                // R5
      irq1_req_q         <= irq1_d;                                // R6
      osc_restart_q      <= wake_d;                                // R10
      wake_irq_q         <= wake_d;                                // R10
      suspend_block_q    <= block_d;                               // R11
      irq0_prev_q        <= pa_s2_q[0];
      pa1_prev_q         <= pa_s2_q[1];
      pa3_prev_q         <= pa_s2_q[3];
      port_a_in_q        <= pa_s2_q;
      port_b_in_q        <= bus_mode ? 8'h00 : pb_s2_q;
      port_e1_in_q       <= HAS_CORE_CLOCK_OUTPUT_PIN ? 1'b0 : pe_s2_q;
      fifo_data_bus_in_q <= bus_mode ? pb_s2_q : 8'h00;            // R17
    end
  end

  // -------------------------------------------------------------------
  // clock output divider from the 48 MHz tick
  // -------------------------------------------------------------------
  logic [1:0] div_q;
  logic       clk_lvl_q;
  wire  [1:0] spd = cpu_control_status_reg[pmx_pkg::CPU_SPD_LSB +: 2];
  // one toggle per tick at 48, per 2 at 24, per 4 at 12 (R1)
  wire  [1:0] div_lim = (spd == pmx_pkg::SPD_48) ? 2'h0 :
                        (spd == pmx_pkg::SPD_24) ? 2'h1 : 2'h3;    // R1
  wire        toggle  = clk48_tick & (div_q >= div_lim);
  wire        clk_tri = cpu_control_status_reg[pmx_pkg::CPU_CLK_TRI_BIT];

  // divider restarts at reset so the default 12 MHz is phase-clean
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      div_q     <= pmx_pkg::RST_DIV;                               // R2
      clk_lvl_q <= 1'b0;
    end
    else
    begin
      div_q     <= toggle ? 2'h0 : (clk48_tick ? div_q + 2'h1 : div_q);
      clk_lvl_q <= toggle ? ~clk_lvl_q : clk_lvl_q;                // R1
    end
  end

  // pad driver; the no-clock variant turns the pad into port e bit 1
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      core_clock_output_pin_o  <= 1'b0;
      core_clock_output_pin_oe <= 1'b0;
    end
    else if (HAS_CORE_CLOCK_OUTPUT_PIN)
    begin
      core_clock_output_pin_o  <= clk_lvl_q;                       // R1
      core_clock_output_pin_oe <= ~clk_tri;                        // R3
    end
    else
    begin
      core_clock_output_pin_o  <= port_e1_dout;                    // R4
      core_clock_output_pin_oe <= port_e1_oe;                      // R4
    end
  end

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  a_clk_tristate: assert property (@(posedge clk) disable iff (!rst_n)
    HAS_CORE_CLOCK_OUTPUT_PIN && clk_tri |=> !core_clock_output_pin_oe) // R3
    else $error("clock pad driven while tri-state requested");
  a_pa_no_alt_drive: assert property (@(posedge clk) disable iff (!rst_n)
    (pa_alt[6:0] & port_a_gpio.oe[6:0]) != 0 |=>
      (port_a_pins.oe[6:0] & $past(pa_alt[6:0])) == 0) // R19
    else $error("port a alternate input driven");
  a_flag_drive: assert property (@(posedge clk) disable iff (!rst_n)
    sel_flag7 |=> port_a_pins.oe[7] &&
      port_a_pins.o[7] == $past(fifo_status_flag_four)) // R15
    else $error("status flag not driven on pa7");
  a_pb_bus: assert property (@(posedge clk) disable iff (!rst_n)
    bus_mode |=> port_b_pins.o == $past(fifo_data_bus_out)) // R17
    else $error("port b not carrying data bus");
  a_cs_gates: assert property (@(posedge clk) disable iff (!rst_n)
    sel_cs7 && pa_s2_q[7] |=> !fifo_ctl_q.pkt_commit &&
      !fifo_ctl_q.data_oe) // R16
    else $error("strobe passed without chip select");
  a_suspend_block: assert property (@(posedge clk) disable iff (!rst_n)
    !wake_en |=> !suspend_block_q) // R11
    else $error("suspend blocked with wakeup disabled");
  a_wake_needs_en: assert property (@(posedge clk) disable iff (!rst_n)
    wake_irq_q |-> $past(wake_en) && $past(cpu_suspended)) // R10
    else $error("wakeup without enable or suspend");
  a_irq0_level: assert property (@(posedge clk) disable iff (!rst_n)
    sel_irq0 && !irq0_trigger_type && !pa_s2_q[0] |=> irq0_req_q) // R5
    else $error("level irq0 missed");
  a_irq1_edge: assert property (@(posedge clk) disable iff (!rst_n)
    irq1_req_q && $past(irq1_trigger_type) |=> !irq1_req_q) // R6
    else $error("edge irq1 longer than one cycle");
  a_reset_release: assert property (@(posedge clk)
    !rst_n |=> port_a_pins.oe == 8'h00 && port_b_pins.oe == 8'h00) // R18
    else $error("pads driven after reset");
  a_clk_toggle_12: assert property (@(posedge clk) disable iff (!rst_n)
    toggle && spd == pmx_pkg::SPD_12 |=> div_q == 2'h0) // R2
    else $error("divider not restarted");

  c_fifo_commit: cover property (@(posedge clk) fifo_ctl_q.pkt_commit);
  c_wakeup: cover property (@(posedge clk) wake_irq_q);
  c_flag_mode: cover property (@(posedge clk) sel_flag7 && fifo_mode);
  c_clk_tri: cover property (@(posedge clk) clk_tri && rst_n);

endmodule

`default_nettype wire

/* rtl/pmx_pkg.sv */
// package for the port a / port b / clock output pin multiplexer
// assumes a single 25 MHz core clock and synchronous active-low reset
package pmx_pkg;

  // -------------------------------------------------------------------
  // interface configuration field encodings
  // -------------------------------------------------------------------
  localparam logic [1:0] IFC_PORTS      = 2'h0;
  localparam logic [1:0] IFC_RESERVED   = 2'h1;
  localparam logic [1:0] IFC_PROG_IF    = 2'h2;
  localparam logic [1:0] IFC_SLAVE_FIFO = 2'h3;

  // -------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------
  localparam int CPU_CLK_TRI_BIT   = 1;   // clock output tri-state
  localparam int CPU_SPD_LSB       = 3;   // clock speed field, 2 bits
  localparam int POL_DATA_OE_BIT   = 4;   // data oe polarity
  localparam int POL_PKT_BIT       = 5;   // packet commit polarity
  localparam int WAKE_EN_BIT       = 1;   // second wakeup enable
  localparam int WAKE_POL_BIT      = 4;   // second wakeup polarity
  localparam int WAKE_PA3SEL_BIT   = 7;   // pa3 alt selection
  localparam int PACFG_IRQ0_BIT    = 0;
  localparam int PACFG_IRQ1_BIT    = 1;
  localparam int PACFG_FLAG_BIT    = 7;

  // -------------------------------------------------------------------
  // clock speed codes for the divider (driven from a 48 MHz tick)
  // -------------------------------------------------------------------
  localparam logic [1:0] SPD_12 = 2'h0;
  localparam logic [1:0] SPD_24 = 2'h1;
  localparam logic [1:0] SPD_48 = 2'h2;

  // -------------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_DIV  = 2'h0;

  // -------------------------------------------------------------------
  // carriers
  // -------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] dout;   // port register value
    logic [7:0] oe;     // port output enables
  } pmx_gpio_t;

  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
  } pmx_pins_t;

  typedef struct packed {
    logic       data_oe;       // slave data output enable, active high
    logic [1:0] fifo_sel;      // selected slave fifo
    logic       pkt_commit;    // packet commit, active high
    logic       cs_ok;         // chip select lets strobes through
  } pmx_fifo_ctl_t;

endpackage

/* tb/pmx_fifo_master.sv */
// far-side model: an external fifo master driving the port a pins
// assumes the bench changes its commands just after a rising clk edge
`timescale 1ns/10ps
`default_nettype none

module pmx_fifo_master
  (
  input  wire logic       active,
  input  wire logic [1:0] sel,
  input  wire logic       commit,
  input  wire logic       cs,
  input  wire logic       rd_oe,
  input  wire logic [7:0] pol,
  input  wire logic [7:0] aux,
  output logic      [7:0] drv
  );
  // ---------------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------------
  // the master never floats a line, so pads never settle to a guessed level
  always_comb
  begin
    drv = aux;
    if (active)
    begin
      drv[5:4] = sel;
      drv[6]   = commit ~^ pol[pmx_pkg::POL_PKT_BIT];
      drv[2]   = rd_oe ~^ pol[pmx_pkg::POL_DATA_OE_BIT];
      drv[7]   = ~cs;
    end
  end
endmodule

`default_nettype wire

/* tb/pmx_pin_mux_tb.sv */
// self-checking bench for the clock, port a and port b pin multiplexer
// assumes one 25 MHz clock; the fifo master model sits on port a
`timescale 1ns/10ps
`default_nettype none

module pmx_pin_mux_tb;
  logic                   clk = 1'b0, rst_n = 1'b0, clk48_tick = 1'b0;
  logic                   irq0_trigger_type = 1'b0, irq1_trigger_type = 1'b0;
  logic                   cpu_suspended = 1'b0, fifo_status_flag_four = 1'b0;
  logic                   port_e1_dout = 1'b0, port_e1_oe = 1'b0;
  logic                   core_clock_output_pin_i = 1'b0;
  logic                   fifo_data_bus_drive = 1'b0;
  logic [1:0]             interface_config_field = 2'h0;
  logic [7:0]             cpu_control_status_reg = 8'h00, wakeup_reg = 8'h00;
  logic [7:0]             port_a_alt_config = 8'h00;
  logic [7:0]             fifo_pin_polarity_reg = 8'h00;
  logic [7:0]             fifo_data_bus_out = 8'h00;
  logic [7:0]             port_a_pin_i, port_b_pin_i;
  pmx_pkg::pmx_gpio_t     port_a_gpio = '0, port_b_gpio = '0;
  logic                   core_clock_output_pin_o, core_clock_output_pin_oe;
  logic                   port_e1_in_q, irq0_req_q, irq1_req_q;
  logic                   osc_restart_q, wake_irq_q, suspend_block_q;
  pmx_pkg::pmx_pins_t     port_a_pins, port_b_pins, exp_p;
  logic [7:0]             port_a_in_q, port_b_in_q, fifo_data_bus_in_q;
  pmx_pkg::pmx_fifo_ctl_t fifo_ctl_q, exp_c;
  logic                   m_act = 1'b0, m_commit = 1'b0, m_cs = 1'b0;
  logic                   m_oe = 1'b0, prev_clk = 1'b0;
  logic [1:0]             m_sel = 2'h0;
  logic [7:0]             m_aux = 8'hFF, m_drv, pb_far = 8'h00;
  logic [31:0]            seed = 32'h6A274B97, r;
  int                     failures = 0, checked = 0, tgl = 0;
  int                     t12, t24, t48, i, b, n;
  int                     pc[4] = '{0, 0, 0, 0};

  pmx_pin_mux #(.HAS_CORE_CLOCK_OUTPUT_PIN(1'b1)) DUT (.*);
  pmx_fifo_master far_end
    (.active(m_act), .sel(m_sel), .commit(m_commit), .cs(m_cs),
     .rd_oe(m_oe), .pol(fifo_pin_polarity_reg), .aux(m_aux), .drv(m_drv));

  // pads: the device wins where it drives, otherwise the far side shows
  assign port_a_pin_i = (port_a_pins.oe & port_a_pins.o) |
                        (~port_a_pins.oe & m_drv);
  assign port_b_pin_i = (port_b_pins.oe & port_b_pins.o) |
                        (~port_b_pins.oe & pb_far);

  always #20 clk = ~clk;

  // clock pad toggles and pulse cycles, counted for later comparison
  always @(posedge clk)
  begin
    prev_clk <= core_clock_output_pin_o;
    if (rst_n)
    begin
      tgl   <= tgl + (core_clock_output_pin_o !== prev_clk);
      pc[0] <= pc[0] + (irq0_req_q === 1'b1);
      pc[1] <= pc[1] + (irq1_req_q === 1'b1);
      pc[2] <= pc[2] + (osc_restart_q === 1'b1);
      pc[3] <= pc[3] + (wake_irq_q === 1'b1);
    end
  end

  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // rates are compared as ratios; window edges may cost one toggle
  function automatic logic near(int a, int e);
    return (a - e <= 1) && (e - a <= 1);
  endfunction

  function automatic pmx_pkg::pmx_pins_t exp_pa(pmx_pkg::pmx_gpio_t g,
                                                logic f7, logic fl);
    exp_pa = '{o: g.dout, oe: g.oe};
    if (f7)
    begin
      exp_pa.o[7]  = fl;
      exp_pa.oe[7] = 1'b1;
    end
  endfunction

  task automatic chk_val(string nm, logic [15:0] e, logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_cnt(string nm, int e, int g);
    checked++;
    if (g != e)
    begin
      failures++;
      $display("ERROR %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic wt(int k);
    repeat (k) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic meas(logic [1:0] s, output int t);
    int t0;
    @(posedge clk);
    cpu_control_status_reg <= {3'h0, s, 3'h0};
    wt(8);
    t0 = tgl;
    wt(64);
    t = tgl - t0;
  endtask

  // pulse count packs osc restarts in hundreds and wake irqs in units
  task automatic wake_try(logic [7:0] w, logic s);
    int k;
    @(posedge clk);
    wakeup_reg    <= w;
    cpu_suspended <= s;
    m_aux         <= 8'hF7;
    wt(5);
    k = pc[2] * 100 + pc[3];
    chk_val("block low", w[1] & ~w[4], suspend_block_q);
    @(posedge clk);
    m_aux <= 8'hFF;
    wt(3);
    chk_val("block high", w[1] & w[4], suspend_block_q);
    @(posedge clk);
    m_aux <= 8'hF7;
    wt(6);
    chk_cnt("wake pulses", (w[1] & s) ? 202 : 0, pc[2] * 100 + pc[3] - k);
  endtask

  task automatic end_of_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ---------------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------------
  initial
  begin
    @(negedge clk);
    chk_val("oe in reset", 16'h0000, {port_a_pins.oe, port_b_pins.oe});
    repeat (4) @(posedge clk);
    rst_n      <= 1'b1;
    clk48_tick <= 1'b1;
    wt(2);
    chk_val("oe after reset", 16'h0000, {port_a_pins.oe, port_b_pins.oe});
    chk_val("clk oe", 16'h0001, core_clock_output_pin_oe);
    meas(pmx_pkg::SPD_12, t12);
    meas(pmx_pkg::SPD_24, t24);
    meas(pmx_pkg::SPD_48, t48);
    chk_cnt("clk 12 runs", 1, t12 > 2);
    chk_cnt("clk 24 vs 12", 1, near(t24, 2 * t12));
    chk_cnt("clk 48 vs 24", 1, near(t48, 2 * t24));
    @(posedge clk);
    cpu_control_status_reg <= 8'h02;
    core_clock_output_pin_i <= 1'b1;
    wt(1);
    chk_val("clk tristate", 16'h0000, core_clock_output_pin_oe);
    // port modes: gpio everywhere except an optional flag on pa7
    for (i = 0; i < 8; i++)
    begin
      r = rnd();
      @(posedge clk);
      interface_config_field <= {1'b0, i[0]};
      port_a_gpio            <= r[15:0];
      port_b_gpio            <= r[31:16];
      r = rnd();
      m_aux                  <= r[7:0];
      pb_far                 <= r[15:8];
      fifo_status_flag_four  <= r[16];
      port_a_alt_config      <= {r[17], 7'h00};
      wt(1);
      exp_p = exp_pa(port_a_gpio, port_a_alt_config[7], fifo_status_flag_four);
      chk_val("pa pins", exp_p, port_a_pins);
      chk_val("pb pins", port_b_gpio, port_b_pins);
      wt(3);
      chk_val("pa in", (exp_p.oe & exp_p.o) | (~exp_p.oe & m_aux),
              port_a_in_q);
      chk_val("pb in", {8'h00, (port_b_gpio.oe & port_b_gpio.dout) |
              (~port_b_gpio.oe & pb_far)}, {fifo_data_bus_in_q, port_b_in_q});
    end
    // bus modes with the fifo master working the control pins
    for (i = 0; i < 12; i++)
    begin
      r = rnd();
      @(posedge clk);
      interface_config_field <= {1'b1, r[0]};
      port_a_alt_config      <= 8'h00;
      fifo_pin_polarity_reg  <= {2'h0, r[2:1], 4'h0};
      m_act                  <= 1'b1;
      m_sel                  <= r[4:3];
      m_commit               <= r[5];
      m_cs                   <= r[6];
      m_oe                   <= r[7];
      fifo_data_bus_out      <= r[15:8];
      fifo_data_bus_drive    <= r[16];
      pb_far                 <= r[24:17];
      port_a_gpio            <= {r[31:24], 8'hFF};
      wt(1);
      chk_val("pa alt oe", (interface_config_field ==
              pmx_pkg::IFC_SLAVE_FIFO) ? 16'h0000 : 16'h00F4,
              port_a_pins.oe & 8'hF4);
      chk_val("bus drive", {fifo_data_bus_out & {8{fifo_data_bus_drive}},
              {8{fifo_data_bus_drive}}},
              {port_b_pins.o & port_b_pins.oe, port_b_pins.oe});
      wt(3);
      exp_c = '{data_oe: m_oe & m_cs, fifo_sel: m_sel,
                pkt_commit: m_commit & m_cs, cs_ok: m_cs};
      if (interface_config_field != pmx_pkg::IFC_SLAVE_FIFO)
        exp_c = '0;
      chk_val("fifo ctl", exp_c, fifo_ctl_q);
      chk_val("bus in", {fifo_data_bus_drive ? fifo_data_bus_out : pb_far,
              8'h00}, {fifo_data_bus_in_q, port_b_in_q});
    end
    @(posedge clk);
    m_act                  <= 1'b0;
    interface_config_field <= pmx_pkg::IFC_PORTS;
    fifo_data_bus_drive    <= 1'b0;
    port_a_gpio            <= '0;
    // external interrupts: level, deselected, then falling edge
    for (b = 0; b < 2; b++)
    begin
      @(posedge clk);
      port_a_alt_config <= 8'h01 << b;
      irq0_trigger_type <= 1'b0;
      irq1_trigger_type <= 1'b0;
      m_aux             <= 8'hFF ^ (8'h01 << b);
      wt(3);
      chk_val("irq level", 16'h0001, b ? irq1_req_q : irq0_req_q);
      @(posedge clk);
      port_a_alt_config <= 8'h00;
      wt(3);
      chk_val("irq off", 16'h0000, b ? irq1_req_q : irq0_req_q);
      @(posedge clk);
      port_a_alt_config <= 8'h01 << b;
      irq0_trigger_type <= 1'b1;
      irq1_trigger_type <= 1'b1;
      m_aux             <= 8'hFF;
      wt(5);
      n = pc[b];
      @(posedge clk);
      m_aux <= 8'hFF ^ (8'h01 << b);
      wt(10);
      chk_cnt("irq edge pulses", 1, pc[b] - n);
    end
    @(posedge clk);
    port_a_alt_config <= 8'h00;
    wake_try(8'h92, 1'b1);
    wake_try(8'h82, 1'b1);
    wake_try(8'h90, 1'b1);
    wake_try(8'h92, 1'b0);
    @(posedge clk);
    wakeup_reg  <= 8'h80;
    port_a_gpio <= 16'h0808;
    wt(1);
    chk_val("pa3 gpio", 16'h0003, {port_a_pins.o[3], port_a_pins.oe[3]});
    chk_val("port e1 in", 16'h0000, port_e1_in_q);
    end_of_test();
  end

  // watchdog: the sequence needs well under two thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    failures++;
    end_of_test();
  end
endmodule

`default_nettype wire
